// *** common/auth_cmd_map.svh ***
`ifndef AUTH_CMD_MAP_SVH
`define AUTH_CMD_MAP_SVH

// Register offsets on the command port
`define REG_OPCODE 4'h0
`define REG_MODE 4'h1
`define REG_SECOND_LO 4'h2
`define REG_SECOND_HI 4'h3
`define REG_CHALLENGE 4'h4
`define REG_CTRL 4'h5
`define REG_STATUS 4'h6
`define REG_RESP_LEN 4'h7
`define REG_RESP 4'h8

// Field positions
`define CTRL_START_BIT 0
`define CTRL_ACK_BIT 1
`define ZONE_SEL_BIT 0
`define ZONE_NOCRC_BIT 7
`define MODE_TEMP_CHAL_BIT 0
`define MODE_TEMP_KEY_BIT 1
`define MODE_SRC_BIT 2
`define MODE_OTP88_BIT 4
`define MODE_OTP64_BIT 5
`define MODE_SERIAL_BIT 6

// Opcodes and answer codes
`define OP_MAC 8'h08
`define OP_HMAC 8'h11
`define OP_LOCK 8'h17
`define ST_OK 8'h00
`define ST_FAIL 8'h01
`define ST_PARSE 8'h03
`define ST_EXEC 8'h0F

// Zones, lock bytes and hashing constants
`define ZONE_CFG 2'h0
`define ZONE_OTP 2'h1
`define ZONE_DATA 2'h2
`define LOCK_VAL 8'hFF
`define LOCK_DATA_ADDR 10'h056
`define LOCK_CFG_ADDR 10'h057
`define CFG_BYTES 10'h058
`define KEY_BLOCK 10'h040
`define IPAD 8'h36
`define OPAD 8'h5C
`define PAD_MARK 8'h80
`define LEN_MAC 10'h058
`define TOT_MAC 10'h080
`define LEN_INNER 10'h098
`define TOT_INNER 10'h0C0
`define LEN_OUTER 10'h060
`define TOT_OUTER 10'h080
`define CRC_POLY 16'h8005

`endif

// *** common/auth_cmd_pkg.sv ***
package auth_cmd_pkg;
   typedef enum logic [9:0] {
      ST_IDLE = 10'h001,
      ST_CHECK = 10'h002,
      ST_ISSUE = 10'h004,
      ST_MWAIT = 10'h008,
      ST_LOAD = 10'h010,
      ST_SEND = 10'h020,
      ST_HWAIT = 10'h040,
      ST_CRCCHK = 10'h080,
      ST_LOCKWR = 10'h100,
      ST_FINISH = 10'h200
   } state_type;
   typedef enum logic [1:0] {
      PASS_MAC = 2'h0,
      PASS_INNER = 2'h1,
      PASS_OUTER = 2'h2,
      PASS_CRC = 2'h3
   } pass_type;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [1:0] zone;
      logic [9:0] addr;
      logic [7:0] wdata;
   } mem_req_type;
   typedef struct packed {
      logic first;
      logic last;
      logic [7:0] data;
   } sha_beat_type;
endpackage

// *** verilog/crc16_byte.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "auth_cmd_map.svh"
module crc16_byte #(
   parameter logic [15:0] POLY = `CRC_POLY
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_clear,
   input wire logic i_en,
   input wire logic [7:0] i_byte,
   output logic [15:0] o_crc
);
   logic [15:0] crc_next;

   // One byte per enable, least significant bit first
   always_comb begin
      crc_next = o_crc;
      for (int i = 0; i < 8; i++) begin
         if (crc_next[15] ^ i_byte[i]) begin
            crc_next = {crc_next[14:0], 1'b0} ^ POLY;
         end else begin
            crc_next = {crc_next[14:0], 1'b0};
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n || i_clear) begin
         o_crc <= 16'h0000;
      end else if (i_en) begin
         o_crc <= crc_next;
      end
   end
endmodule // crc16_byte
`default_nettype wire

// *** verilog/auth_digest_and_zone_lock_cmds.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "auth_cmd_map.svh"
module auth_digest_and_zone_lock_cmds #(
   parameter int DATA_BYTES = 512,
   parameter int OTP_BYTES = 64
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   output var auth_cmd_pkg::mem_req_type o_mem_req,
   input wire logic [7:0] i_mem_byte,
   input wire logic [255:0] i_temp_digest,
   input wire logic i_digest_source_flag,
   input wire logic [71:0] i_unit_serial,
   input wire logic [7:0] i_config_lock_byte,
   input wire logic [7:0] i_data_lock_byte,
   output var auth_cmd_pkg::sha_beat_type o_sha_beat,
   output logic o_sha_valid,
   input wire logic i_sha_ready,
   input wire logic i_sha_done,
   input wire logic [255:0] i_sha_digest
);
   localparam logic [9:0] DATA_N = 10'(DATA_BYTES);
   localparam logic [9:0] ZONE_N = 10'(DATA_BYTES + OTP_BYTES);

   auth_cmd_pkg::state_type state_reg, state_next;
   auth_cmd_pkg::pass_type pass_reg;
   logic [9:0] pos_reg;
   logic [7:0] opcode_reg, mode_reg;
   logic [15:0] p2_reg;
   logic [255:0] chal_reg, inner_reg, resp_reg;
   logic resp_len_reg, done_reg, err_reg;
   logic [4:0] rd_ptr_reg;
   logic [7:0] fin_code;
   logic fin_dig;
   logic [15:0] crc_val;

   // Register port decode; inputs share our clock, so no synchroniser
   wire busy = (state_reg != auth_cmd_pkg::ST_IDLE);
   wire wr_ok = i_reg_wr && !busy;
   wire wr_ctrl = i_reg_wr && (i_reg_addr == `REG_CTRL);
   wire start_w = wr_ctrl && i_reg_wdata[`CTRL_START_BIT] && !busy;
   wire ack_w = wr_ctrl && i_reg_wdata[`CTRL_ACK_BIT];
   wire rd_resp = i_reg_rd && (i_reg_addr == `REG_RESP);
   wire [7:0] resp_byte = resp_reg[8'(255 - 8 * rd_ptr_reg) -: 8];
   wire [7:0] rd_mux =
      (i_reg_addr == `REG_OPCODE) ? opcode_reg :
      (i_reg_addr == `REG_MODE) ? mode_reg :
      (i_reg_addr == `REG_SECOND_LO) ? p2_reg[7:0] :
      (i_reg_addr == `REG_SECOND_HI) ? p2_reg[15:8] :
      (i_reg_addr == `REG_STATUS) ? {5'h00, err_reg, done_reg, busy} :
      (i_reg_addr == `REG_RESP_LEN) ? (resp_len_reg ? 8'h20 : 8'h01) :
      (i_reg_addr == `REG_RESP) ? resp_byte : 8'h00;

   // Command checks
   wire is_mac = (opcode_reg == `OP_MAC);
   wire is_hmac = (opcode_reg == `OP_HMAC);
   wire is_lock = (opcode_reg == `OP_LOCK);
   wire flag_eq = (mode_reg[`MODE_SRC_BIT] == i_digest_source_flag);
   wire mac_rsv = mode_reg[7] || mode_reg[3];
   wire hmac_rsv = mac_rsv || mode_reg[1] || mode_reg[0];
   wire mac_tk = mode_reg[`MODE_TEMP_CHAL_BIT] || mode_reg[`MODE_TEMP_KEY_BIT];
   wire lock_rsv = |mode_reg[6:1];
   wire zone_data = mode_reg[`ZONE_SEL_BIT];
   wire zone_locked = zone_data ? (i_data_lock_byte == `LOCK_VAL)
                                : (i_config_lock_byte == `LOCK_VAL);

   // Stream geometry of the current pass
   wire is_crc = (pass_reg == auth_cmd_pkg::PASS_CRC);
   wire is_hm = (pass_reg == auth_cmd_pkg::PASS_INNER) ||
                (pass_reg == auth_cmd_pkg::PASS_OUTER);
   wire [9:0] len_w = (pass_reg == auth_cmd_pkg::PASS_MAC) ? `LEN_MAC :
                      (pass_reg == auth_cmd_pkg::PASS_INNER) ? `LEN_INNER :
                      `LEN_OUTER;
   wire [9:0] tot_w = is_crc ? (zone_data ? ZONE_N : `CFG_BYTES) :
                      (pass_reg == auth_cmd_pkg::PASS_INNER) ? `TOT_INNER :
                      (pass_reg == auth_cmd_pkg::PASS_MAC) ? `TOT_MAC :
                      `TOT_OUTER;
   wire [15:0] len_bits = {3'h0, len_w, 3'h0};
   wire last_pos = (pos_reg == tot_w - 10'h001);
   wire [9:0] m_idx = is_hm ? pos_reg - `KEY_BLOCK : pos_reg;
   wire [8:0] slot_base = {p2_reg[3:0], 5'h00};

   // Byte source of stream position pos_reg
   logic need_mem;
   logic [1:0] mem_zone;
   logic [9:0] mem_addr;
   logic [7:0] fix_byte, xor_byte;
   always_comb begin
      need_mem = 1'b0;
      mem_zone = `ZONE_DATA;
      mem_addr = 10'h000;
      fix_byte = 8'h00;
      xor_byte = 8'h00;
      if (is_crc) begin
         need_mem = 1'b1;
         if (!zone_data) begin
            mem_zone = `ZONE_CFG;
            mem_addr = pos_reg;
         end else if (pos_reg < DATA_N) begin
            mem_addr = pos_reg;
         end else begin
            mem_zone = `ZONE_OTP;
            mem_addr = pos_reg - DATA_N;
         end
      end else if (pos_reg >= len_w) begin
         // Standard SHA-256 padding and bit length
         if (pos_reg == len_w) begin
            fix_byte = `PAD_MARK;
         end else if (pos_reg == tot_w - 10'h002) begin
            fix_byte = len_bits[15:8];
         end else if (last_pos) begin
            fix_byte = len_bits[7:0];
         end
      end else if (is_hm && pos_reg < `KEY_BLOCK) begin
         // Key block, slot key then zeros, xored with the pad
         xor_byte = (pass_reg == auth_cmd_pkg::PASS_INNER) ? `IPAD : `OPAD;
         if (pos_reg < 10'h020) begin
            need_mem = 1'b1;
            mem_addr = {1'b0, slot_base | {4'h0, pos_reg[4:0]}};
         end
      end else if (pass_reg == auth_cmd_pkg::PASS_OUTER) begin
         fix_byte = inner_reg[8'(255 - 8 * m_idx[4:0]) -: 8];
      end else if (m_idx < 10'h020) begin
         if (is_mac && mode_reg[`MODE_TEMP_KEY_BIT]) begin
            fix_byte = i_temp_digest[8 * m_idx[4:0] +: 8];
         end else if (is_mac) begin
            need_mem = 1'b1;
            mem_addr = {1'b0, slot_base | {4'h0, m_idx[4:0]}};
         end
      end else if (m_idx < 10'h040) begin
         if (is_hmac || mode_reg[`MODE_TEMP_CHAL_BIT]) begin
            fix_byte = i_temp_digest[8 * m_idx[4:0] +: 8];
         end else begin
            fix_byte = chal_reg[8 * m_idx[4:0] +: 8];
         end
      end else if (m_idx == 10'h040) begin
         fix_byte = opcode_reg;
      end else if (m_idx == 10'h041) begin
         fix_byte = mode_reg;
      end else if (m_idx < 10'h044) begin
         fix_byte = m_idx[0] ? p2_reg[15:8] : p2_reg[7:0];
      end else if (m_idx < 10'h04F) begin
         mem_zone = `ZONE_OTP;
         mem_addr = m_idx - 10'h044;
         need_mem = mode_reg[`MODE_OTP88_BIT] ||
                    (m_idx < 10'h04C && mode_reg[`MODE_OTP64_BIT]);
      end else if (m_idx == 10'h04F) begin
         fix_byte = i_unit_serial[71:64];
      end else if (m_idx < 10'h054) begin
         if (mode_reg[`MODE_SERIAL_BIT]) begin
            fix_byte = i_unit_serial[8 * (m_idx - 10'h04C) +: 8];
         end
      end else if (m_idx < 10'h056) begin
         fix_byte = i_unit_serial[8 * (m_idx - 10'h054) +: 8];
      end else if (mode_reg[`MODE_SERIAL_BIT]) begin
         fix_byte = i_unit_serial[8 * (m_idx - 10'h054) +: 8];
      end
   end

   wire [7:0] cur_byte = (need_mem ? i_mem_byte : fix_byte) ^ xor_byte;
   wire crc_en = (state_reg == auth_cmd_pkg::ST_LOAD) && is_crc;
   wire crc_clr = (state_reg == auth_cmd_pkg::ST_CHECK);

   crc16_byte u_crc (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_clear(crc_clr),
      .i_en(crc_en),
      .i_byte(cur_byte),
      .o_crc(crc_val)
   );

   // Sequencer: decides error, walk of passes, and the final answer
   always_comb begin
      state_next = state_reg;
      fin_code = `ST_OK;
      fin_dig = 1'b0;
      unique case (state_reg)
         auth_cmd_pkg::ST_IDLE: begin
            if (start_w) state_next = auth_cmd_pkg::ST_CHECK;
         end
         auth_cmd_pkg::ST_CHECK: begin
            state_next = auth_cmd_pkg::ST_FINISH;
            if (is_lock) begin
               if (zone_locked) fin_code = `ST_FAIL;
               else if (lock_rsv) fin_code = `ST_PARSE;
               else if (mode_reg[`ZONE_NOCRC_BIT])
                  state_next = auth_cmd_pkg::ST_LOCKWR;
               else state_next = auth_cmd_pkg::ST_ISSUE;
            end else if (is_hmac) begin
               if (hmac_rsv) fin_code = `ST_PARSE;
               else if (!flag_eq) fin_code = `ST_EXEC;
               else state_next = auth_cmd_pkg::ST_ISSUE;
            end else if (is_mac) begin
               if (mac_rsv) fin_code = `ST_PARSE;
               else if (mac_tk && !flag_eq) fin_code = `ST_EXEC;
               else state_next = auth_cmd_pkg::ST_ISSUE;
            end else begin
               fin_code = `ST_PARSE;
            end
         end
         auth_cmd_pkg::ST_ISSUE: state_next = auth_cmd_pkg::ST_MWAIT;
         auth_cmd_pkg::ST_MWAIT: state_next = auth_cmd_pkg::ST_LOAD;
         auth_cmd_pkg::ST_LOAD: begin
            if (!is_crc) state_next = auth_cmd_pkg::ST_SEND;
            else if (last_pos) state_next = auth_cmd_pkg::ST_CRCCHK;
            else state_next = auth_cmd_pkg::ST_ISSUE;
         end
         auth_cmd_pkg::ST_SEND: begin
            if (i_sha_ready && last_pos) state_next = auth_cmd_pkg::ST_HWAIT;
            else if (i_sha_ready) state_next = auth_cmd_pkg::ST_ISSUE;
         end
         auth_cmd_pkg::ST_HWAIT: begin
            if (i_sha_done && pass_reg == auth_cmd_pkg::PASS_INNER) begin
               state_next = auth_cmd_pkg::ST_ISSUE;
            end else if (i_sha_done) begin
               state_next = auth_cmd_pkg::ST_FINISH;
               fin_dig = 1'b1;
            end
         end
         auth_cmd_pkg::ST_CRCCHK: begin
            if (crc_val == p2_reg) begin
               state_next = auth_cmd_pkg::ST_LOCKWR;
            end else begin
               state_next = auth_cmd_pkg::ST_FINISH;
               fin_code = `ST_EXEC;
            end
         end
         auth_cmd_pkg::ST_LOCKWR: state_next = auth_cmd_pkg::ST_FINISH;
         auth_cmd_pkg::ST_FINISH: state_next = auth_cmd_pkg::ST_IDLE;
      endcase
   end

   wire go_fin = (state_next == auth_cmd_pkg::ST_FINISH) &&
                 (state_reg != auth_cmd_pkg::ST_FINISH);
   wire sent = (state_reg == auth_cmd_pkg::ST_SEND) && i_sha_ready;
   wire to_outer = (state_reg == auth_cmd_pkg::ST_HWAIT) && i_sha_done &&
                   (pass_reg == auth_cmd_pkg::PASS_INNER);

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) state_reg <= auth_cmd_pkg::ST_IDLE;
      else state_reg <= state_next;
   end

   // Parameters are frozen while a command runs
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         opcode_reg <= 8'h00;
         mode_reg <= 8'h00;
         p2_reg <= 16'h0000;
         chal_reg <= 256'h0;
      end else if (wr_ok) begin
         if (i_reg_addr == `REG_OPCODE) opcode_reg <= i_reg_wdata;
         if (i_reg_addr == `REG_MODE) mode_reg <= i_reg_wdata;
         if (i_reg_addr == `REG_SECOND_LO) p2_reg[7:0] <= i_reg_wdata;
         if (i_reg_addr == `REG_SECOND_HI) p2_reg[15:8] <= i_reg_wdata;
         if (i_reg_addr == `REG_CHALLENGE)
            chal_reg <= {i_reg_wdata, chal_reg[255:8]};
      end
   end

   // Pass and stream position
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n || crc_clr) begin
         pos_reg <= 10'h000;
         pass_reg <= is_lock ? auth_cmd_pkg::PASS_CRC :
                     is_hmac ? auth_cmd_pkg::PASS_INNER :
                     auth_cmd_pkg::PASS_MAC;
      end else if (to_outer) begin
         pos_reg <= 10'h000;
         pass_reg <= auth_cmd_pkg::PASS_OUTER;
      end else if (crc_en || sent) begin
         pos_reg <= pos_reg + 10'h001;
      end
   end

   // Memory port: read request, or the lock byte write
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_mem_req <= '0;
      end else if (state_reg == auth_cmd_pkg::ST_LOCKWR) begin
         o_mem_req.rd <= 1'b0;
         o_mem_req.wr <= 1'b1;
         o_mem_req.zone <= `ZONE_CFG;
         o_mem_req.addr <= zone_data ? `LOCK_DATA_ADDR : `LOCK_CFG_ADDR;
         o_mem_req.wdata <= `LOCK_VAL;
      end else begin
         o_mem_req.rd <= (state_reg == auth_cmd_pkg::ST_ISSUE) && need_mem;
         o_mem_req.wr <= 1'b0;
         o_mem_req.zone <= mem_zone;
         o_mem_req.addr <= mem_addr;
         o_mem_req.wdata <= 8'h00;
      end
   end

   // Hash engine feed, held until the engine takes it
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_sha_valid <= 1'b0;
         o_sha_beat <= '0;
      end else if (state_reg == auth_cmd_pkg::ST_LOAD && !is_crc) begin
         o_sha_valid <= 1'b1;
         o_sha_beat <= {pos_reg == 10'h000, last_pos, cur_byte};
      end else if (sent) begin
         o_sha_valid <= 1'b0;
      end
   end

   // Answer buffer, status flags and register read data
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         inner_reg <= 256'h0;
         resp_reg <= 256'h0;
         resp_len_reg <= 1'b0;
         err_reg <= 1'b0;
         done_reg <= 1'b0;
         rd_ptr_reg <= 5'h00;
         o_reg_rdata <= 8'h00;
      end else begin
         o_reg_rdata <= i_reg_rd ? rd_mux : 8'h00;
         if (to_outer) inner_reg <= i_sha_digest;
         if (go_fin) begin
            resp_reg <= fin_dig ? i_sha_digest : {fin_code, 248'h0};
            resp_len_reg <= fin_dig;
            err_reg <= !fin_dig && (fin_code != `ST_OK);
         end
         // Finish sets done even in the cycle software acknowledges
         done_reg <= (state_reg == auth_cmd_pkg::ST_FINISH) ||
                     (done_reg && !ack_w && !start_w);
         if (start_w) rd_ptr_reg <= 5'h00;
         else if (rd_resp) rd_ptr_reg <= resp_len_reg ? rd_ptr_reg + 5'h01
                                                      : 5'h00;
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   sequence seq_fetch;
      state_reg == auth_cmd_pkg::ST_ISSUE ##1
      state_reg == auth_cmd_pkg::ST_MWAIT ##1
      state_reg == auth_cmd_pkg::ST_LOAD;
   endsequence
   sequence seq_lock_done;
      o_mem_req.wr && o_mem_req.wdata == `LOCK_VAL ##1
      state_reg == auth_cmd_pkg::ST_IDLE && resp_reg[255:248] == `ST_OK &&
      !resp_len_reg && done_reg;
   endsequence

   AST_FETCH_ORDER: assert property (
      state_reg == auth_cmd_pkg::ST_ISSUE |-> seq_fetch)
      else $error("byte fetch sequence broken");
   AST_LOCK_WRITE: assert property (
      state_reg == auth_cmd_pkg::ST_LOCKWR |=> seq_lock_done)
      else $error("lock did not write 0xFF and answer zero");
   AST_LOCKED_FAIL: assert property (
      state_reg == auth_cmd_pkg::ST_CHECK && is_lock && zone_locked |=>
      !o_mem_req.wr ##1 resp_reg[255:248] == `ST_FAIL)
      else $error("locked zone not refused");
   AST_CRC_MISMATCH: assert property (
      state_reg == auth_cmd_pkg::ST_CRCCHK && crc_val != p2_reg |=>
      !o_mem_req.wr ##1 !o_mem_req.wr && err_reg)
      else $error("bad summary still locked");
   AST_NOCRC_LOCK: assert property (
      state_reg == auth_cmd_pkg::ST_CHECK && is_lock && !zone_locked &&
      !lock_rsv && mode_reg[7] |-> ##2 o_mem_req.wr)
      else $error("bypass lock not taken");
   AST_HMAC_SRC: assert property (
      state_reg == auth_cmd_pkg::ST_CHECK && is_hmac && !hmac_rsv &&
      !flag_eq |-> ##2 err_reg && resp_reg[255:248] == `ST_EXEC)
      else $error("source flag mismatch not refused");
   AST_MAC_SRC: assert property (
      state_reg == auth_cmd_pkg::ST_CHECK && is_mac && !mac_rsv && mac_tk &&
      !flag_eq |-> ##2 err_reg && !resp_len_reg)
      else $error("mac source flag mismatch not refused");
   AST_RSV_MODE: assert property (
      state_reg == auth_cmd_pkg::ST_CHECK && (is_mac || is_hmac) &&
      mode_reg[7] |-> ##2 resp_reg[255:248] == `ST_PARSE)
      else $error("reserved mode bit not refused");
   AST_SLOT_ADDR: assert property (
      o_mem_req.rd && o_mem_req.zone == `ZONE_DATA && !is_crc |->
      o_mem_req.addr[8:5] == p2_reg[3:0])
      else $error("key slot address wrong");
   AST_PAD_MARK: assert property (
      o_sha_valid && !is_crc && pos_reg == len_w |->
      o_sha_beat.data == `PAD_MARK)
      else $error("padding marker missing");
   AST_SERIAL_ZERO: assert property (
      o_sha_valid && !is_hm && !mode_reg[6] && m_idx >= 10'h050 &&
      m_idx < 10'h054 |-> o_sha_beat.data == 8'h00)
      else $error("serial bytes leaked");
   AST_OTP_ZERO: assert property (
      o_sha_valid && !is_hm && !mode_reg[4] && m_idx >= 10'h04C &&
      m_idx < 10'h04F |-> o_sha_beat.data == 8'h00)
      else $error("upper OTP bytes leaked");
endmodule // auth_digest_and_zone_lock_cmds
`default_nettype wire

// *** bench/mem_sha_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module mem_sha_model #(
   parameter logic [255:0] DIG = {8{32'h1E2D3C4B}}
) (
   input wire logic i_ref_clk,
   input wire auth_cmd_pkg::mem_req_type i_mem_req,
   output logic [7:0] o_mem_byte,
   input wire auth_cmd_pkg::sha_beat_type i_sha_beat,
   input wire logic i_sha_valid,
   output logic o_sha_ready,
   output logic o_sha_done,
   output logic [255:0] o_sha_digest
);
   logic [7:0] beats [0:255];
   logic [19:0] last_wr;
   int n = 0;
   int n_wr = 0;
   int wait_cnt = 0;
   initial begin
      o_mem_byte = 8'h00;
      o_sha_ready = 1'b0;
      o_sha_done = 1'b0;
      o_sha_digest = ~DIG;
   end
   // Stale data flips each cycle so a late sample shows up
   always @(posedge i_ref_clk) begin
      o_mem_byte <= i_mem_req.rd ? i_mem_req.addr[7:0] ^ 8'hA5 ^
         {6'h00, i_mem_req.zone} : ~o_mem_byte;
      if (i_mem_req.wr) begin
         n_wr <= n_wr + 1;
         last_wr <= {i_mem_req.zone, i_mem_req.addr, i_mem_req.wdata};
      end
      // Ready alternates, so every beat meets one stall
      o_sha_ready <= i_sha_valid ? ~o_sha_ready : 1'b0;
      if (i_sha_valid && o_sha_ready) begin
         beats[i_sha_beat.first ? 0 : n] <= i_sha_beat.data;
         n <= i_sha_beat.first ? 1 : n + 1;
         if (i_sha_beat.last) wait_cnt <= 6;
      end else if (wait_cnt > 0) begin
         wait_cnt <= wait_cnt - 1;
      end
      o_sha_done <= (wait_cnt == 1);
      o_sha_digest <= (wait_cnt == 1) ? DIG : ~DIG;
   end
endmodule // mem_sha_model
`default_nettype wire

// *** bench/auth_digest_and_zone_lock_cmds_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module auth_digest_and_zone_lock_cmds_bench;
   localparam logic [255:0] DIG = {8{32'h1E2D3C4B}};
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, rd_d = 0, valid, ready, done;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, mem_byte, cfg_lk = 8'h00, v;
   logic [7:0] data_lk = 8'h00, ch0;
   logic src = 1'b0;
   logic [255:0] temp, dig;
   logic [71:0] serial;
   logic [15:0] crc, p2;
   logic [8:0] e;
   logic [8:0] exp_q [$];
   auth_cmd_pkg::mem_req_type req;
   auth_cmd_pkg::sha_beat_type beat;
   integer seed = 32'hf1a9, mismatches = 0, n_tests = 0;
   always #25 clk = ~clk;
   auth_digest_and_zone_lock_cmds #(.DATA_BYTES(64), .OTP_BYTES(16)) dut_u (
      .i_ref_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
      .o_mem_req(req), .i_mem_byte(mem_byte), .i_temp_digest(temp),
      .i_digest_source_flag(src), .i_unit_serial(serial),
      .i_config_lock_byte(cfg_lk), .i_data_lock_byte(data_lk),
      .o_sha_beat(beat), .o_sha_valid(valid), .i_sha_ready(ready),
      .i_sha_done(done), .i_sha_digest(dig));
   mem_sha_model #(.DIG(DIG)) m (.i_ref_clk(clk), .i_mem_req(req),
      .o_mem_byte(mem_byte), .i_sha_beat(beat), .i_sha_valid(valid),
      .o_sha_ready(ready), .o_sha_done(done), .o_sha_digest(dig));
   function automatic logic [7:0] mf(input int z, input int a);
      return a[7:0] ^ 8'hA5 ^ {6'h00, z[1:0]};
   endfunction
   // Bits enter LSB first, no output reflection
   function automatic logic [15:0] crc8(input logic [15:0] c,
         input logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         c = (c << 1) ^ ((d[i] ^ c[15]) ? 16'h8005 : 16'h0000);
      end
      return c;
   endfunction
   task summarize;
      if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task cmp(input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         mismatches++;
         $display("mismatch at %0t: expected %h got %h", $time, x, g);
      end
   endtask
   // One bus cycle; a read notes its expectation, bit 8 means checked
   task rw(input int r, input int a, input int d, input int x);
      @(posedge clk);
      addr <= a[3:0];
      wdata <= d[7:0];
      rd <= r[0];
      wr <= !r[0];
      if (r[0]) exp_q.push_back(x[8:0]);
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
      #1 v = rdata;
   endtask
   always @(posedge clk) rd_d <= rd;
   // Read data stands only in the cycle after the strobe
   always @(negedge clk) if (rd_d) begin
      e = exp_q.pop_front();
      if (e[8]) cmp(e[7:0], rdata);
   end
   task run(input int op, md, p, st);
      int k;
      rw(0, 4'h0, op, 0);
      rw(0, 4'h1, md, 0);
      rw(0, 4'h2, p[7:0], 0);
      rw(0, 4'h3, p[15:8], 0);
      rw(0, 4'h5, 8'h01, 0);
      k = 0;
      v = 8'h00;
      while (v[1] !== 1'b1 && k < 3000) begin
         rw(1, 4'h6, 0, 0);
         k++;
      end
      if (k == 3000) mismatches++;
      rw(1, 4'h7, 0, st[8] ? 9'h101 : 9'h120);
      if (st[8]) rw(1, 4'h8, 0, st);
      else for (k = 0; k < 32; k++) rw(1, 4'h8, 0, {1'b1, DIG[255-8*k -: 8]});
      rw(0, 4'h5, 8'h02, 0);
   endtask
   initial begin
      for (int k = 0; k < 32; k++) temp[8*k +: 8] = 8'hC0 + k[7:0];
      for (int k = 0; k < 9; k++) serial[8*k +: 8] = 8'h90 + k[7:0];
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      cfg_lk <= 8'hFF;
      run(8'h17, 8'h00, 0, 9'h101);
      cfg_lk <= 8'h00;
      data_lk <= 8'hFF;
      run(8'h17, 8'h01, 0, 9'h101);
      data_lk <= 8'h00;
      run(8'h17, 8'h02, 0, 9'h103);
      run(8'h11, 8'h80, 0, 9'h103);
      run(8'h11, 8'h04, 0, 9'h10F);
      run(8'h08, 8'h07, 0, 9'h10F);
      crc = 16'h0000;
      for (int a = 0; a < 88; a++) crc = crc8(crc, mf(0, a));
      run(8'h17, 8'h00, crc ^ 16'h0001, 9'h10F);
      cmp(0, m.n_wr);
      run(8'h17, 8'h00, crc, 9'h100);
      cmp({2'h0, 10'h057, 8'hFF}, m.last_wr);
      crc = 16'h0000;
      for (int a = 0; a < 64; a++) crc = crc8(crc, mf(2, a));
      for (int a = 0; a < 16; a++) crc = crc8(crc, mf(1, a));
      run(8'h17, 8'h01, crc, 9'h100);
      cmp({2'h0, 10'h056, 8'hFF}, m.last_wr);
      run(8'h17, 8'h81, 0, 9'h100);
      cmp(3, m.n_wr);
      p2 = 16'($random(seed));
      // First challenge write lands in message byte 32
      ch0 = 8'($random(seed));
      rw(0, 4'h4, ch0, 0);
      repeat (31) rw(0, 4'h4, 8'($random(seed)), 0);
      run(8'h08, 8'h41, p2, 0);
      cmp(mf(2, p2[3:0] * 32), m.beats[0]);
      cmp(temp[7:0], m.beats[32]);
      cmp({8'h08, 8'h41}, {m.beats[64], m.beats[65]});
      cmp({p2[15:8], p2[7:0]}, {m.beats[67], m.beats[66]});
      cmp({8'h00, 8'h80}, {m.beats[68], m.beats[88]});
      cmp({serial[71:64], serial[39:32]}, {m.beats[79], m.beats[80]});
      cmp(128, m.n);
      // Key from temp digest, challenge from the port, short OTP only
      run(8'h08, 8'h22, p2, 0);
      cmp({temp[7:0], ch0}, {m.beats[0], m.beats[32]});
      cmp({mf(1, 7), 8'h00}, {m.beats[75], m.beats[76]});
      cmp(0, m.beats[80]);
      src <= 1'b1;
      run(8'h11, 8'h14, 16'h0003, 0);
      cmp(mf(2, 96) ^ 8'h5C, m.beats[0]);
      cmp(DIG[255:248], m.beats[64]);
      cmp({8'h11, 8'h14}, {m.beats[128], m.beats[129]});
      cmp({mf(1, 0), mf(1, 10)}, {m.beats[132], m.beats[142]});
      cmp(0, m.beats[144]);
      summarize;
   end
   // Whole run needs well under 40000 cycles
   initial begin
      #2000000;
      mismatches++;
      summarize;
   end
endmodule // auth_digest_and_zone_lock_cmds_bench
`default_nettype wire
